// ---- design/edxs_mc_timer.sv ----
// Machine cycle clock-state counter producing a 2-bit phase count and a one-cycle last-clock enable.
`timescale 1ns/1ps
module edxs_mc_timer
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    output logic [1:0] phase,
    output logic last_clk
);
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;
    always_comb
    begin
        nxt_phase = run ? phase_ff + 2'h1 : 2'h0;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            phase_ff <= 2'h0;
        else
            phase_ff <= nxt_phase;
    end
    assign phase = phase_ff;
    assign last_clk = run && (phase_ff == 2'h3);
endmodule

// ---- design/edxs_pkg.sv ----
// Package with constants for the external data access timing block.
package edxs_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam logic [2:0] CLK_PER_MC = 3'h4;
    localparam logic [2:0] STRETCH_RST = 3'h1;
    localparam logic [31:0] ADDR_CLKCTL = 32'h00000000;
    localparam logic [31:0] ADDR_WAITCTL = 32'h00000004;
    localparam logic [31:0] ADDR_PSEL = 32'h00000008;
    localparam logic [31:0] ADDR_TAKEY = 32'h0000000c;
    localparam logic [31:0] ADDR_CMD = 32'h00000010;
    localparam logic [31:0] ADDR_STAT = 32'h00000014;
    localparam logic [31:0] ADDR_PTR0 = 32'h00000018;
    localparam logic [31:0] ADDR_PTR1 = 32'h0000001c;
    localparam logic [31:0] ADDR_RIP2 = 32'h00000020;
    localparam int STRETCH_LSB = 0;
    localparam int WAIT_EN_BIT = 7;
    localparam logic [7:0] TA_KEY1 = 8'haa;
    localparam logic [7:0] TA_KEY2 = 8'h55;
    localparam logic [2:0] TA_WINDOW = 3'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {EDXS_IDLE, EDXS_FETCH, EDXS_ACCESS, EDXS_DONE} edxs_state_t;
endpackage

// ---- design/edxs_top.sv ----
// External data access controller with stretch and wait timing.
// Contract
// - Each transfer starts with a four clock opcode fetch cycle.
// - The next machine cycle drives the address and performs the access.
// - Stretch value comes from bits 2 to 0 of clock control register.
// - Transfer lasts stretch plus two machine cycles.
// - Stretch lengthens only the transfer; core stays frozen meanwhile.
// - Stretch resets to 1; software may program 0.
// - Strobe is 2 clocks at stretch 0, else four clocks per step.
// - Wait pin is honoured only while wait enable bit 7 is set.
// - Stretch sets the minimum length; waits only extend it.
// - Wait pin sampled in third clock state of each access cycle.
// - Each active sample inserts one wait cycle, strobe held.
// - Waits are unlimited; access ends when wait is released.
// - Wait enable writes take effect only after the timed unlock.
// - Wait input is the port 4 bit 0 alternate function.
// - Pointer accesses use pointer zero or one per pointer select.
// - Indirect address is index register low, port 2 latch high.
// - Pointer select is bit 0; other bits read zero.
`timescale 1ns/1ps
module edxs_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port4_bit0,
    input wire logic [7:0] ext_data_in,
    output logic [15:0] ext_addr,
    output logic [7:0] ext_data_out,
    output logic ext_data_oe,
    output logic ext_rd_n,
    output logic ext_wr_n,
    output logic core_hold
);
    logic [2:0] stretch_select_ff, nxt_stretch_select;
    logic wait_enable_ff, nxt_wait_enable;
    logic pointer_select_ff, nxt_pointer_select;
    logic [15:0] ptr0_ff, nxt_ptr0, ptr1_ff, nxt_ptr1;
    logic [7:0] idx_reg_ff, nxt_idx_reg, p2_latch_ff, nxt_p2_latch;
    logic [1:0] ta_stage_ff, nxt_ta_stage;
    logic [2:0] ta_cnt_ff, nxt_ta_cnt;
    logic [7:0] rd_data_ff, nxt_rd_data;
    logic done_ff, nxt_done;
    logic aw_ok_ff, nxt_aw_ok, w_ok_ff, nxt_w_ok;
    logic [31:0] awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    edxs_pkg::edxs_state_t state_ff, nxt_state;
    logic [3:0] mc_left_ff, nxt_mc_left;
    logic wait_pend_ff, nxt_wait_pend;
    logic is_write_ff, nxt_is_write, use_ptr_ff, nxt_use_ptr, ptr_inc_ff, nxt_ptr_inc;
    logic [15:0] addr_ff, nxt_addr;
    logic [7:0] wbyte_ff, nxt_wbyte;
    logic rd_n_ff, nxt_rd_n, wr_n_ff, nxt_wr_n, oe_ff, nxt_oe;
    logic [1:0] phase;
    logic last_clk, run, do_wr, cmd_go, ta_open;
    assign run = (state_ff == edxs_pkg::EDXS_FETCH) || (state_ff == edxs_pkg::EDXS_ACCESS);
    edxs_mc_timer u_timer
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .phase(phase),
        .last_clk(last_clk)
    );
    assign do_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;
    assign ta_open = (ta_stage_ff == 2'h2);
    assign cmd_go = do_wr && (awaddr_ff == edxs_pkg::ADDR_CMD) && wdata_ff[8]
        && (state_ff == edxs_pkg::EDXS_IDLE);
    // Register file and AXI4-Lite slave.
    always_comb
    begin
        nxt_aw_ok = aw_ok_ff;
        nxt_w_ok = w_ok_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        nxt_stretch_select = stretch_select_ff;
        nxt_wait_enable = wait_enable_ff;
        nxt_pointer_select = pointer_select_ff;
        nxt_ptr0 = ptr0_ff;
        nxt_ptr1 = ptr1_ff;
        nxt_idx_reg = idx_reg_ff;
        nxt_p2_latch = p2_latch_ff;
        nxt_ta_stage = ta_stage_ff;
        nxt_ta_cnt = ta_cnt_ff;
        nxt_done = done_ff;
        if (s_axi_awvalid && !aw_ok_ff)
        begin
            nxt_aw_ok = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ok_ff)
        begin
            nxt_w_ok = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        // The unlock window closes after a few bus writes so a stray write cannot reopen it.
        if (ta_stage_ff != 2'h0 && do_wr)
        begin
            nxt_ta_cnt = ta_cnt_ff - 3'h1;
            if (ta_cnt_ff == 3'h1)
                nxt_ta_stage = 2'h0;
        end
        if (state_ff == edxs_pkg::EDXS_DONE)
            nxt_done = 1'b1;
        if (s_axi_bvalid && s_axi_bready)
            nxt_bvalid = 1'b0;
        if (do_wr)
        begin
            nxt_aw_ok = 1'b0;
            nxt_w_ok = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = edxs_pkg::RESP_OKAY;
            unique case (awaddr_ff)
                edxs_pkg::ADDR_CLKCTL:
                    if (wstrb_ff[0])
                        nxt_stretch_select = wdata_ff[edxs_pkg::STRETCH_LSB +: 3];
                edxs_pkg::ADDR_WAITCTL:
                    if (wstrb_ff[0] && ta_open)
                    begin
                        nxt_wait_enable = wdata_ff[edxs_pkg::WAIT_EN_BIT];
                        nxt_ta_stage = 2'h0;
                    end
                edxs_pkg::ADDR_PSEL:
                    if (wstrb_ff[0])
                        nxt_pointer_select = wdata_ff[0];
                edxs_pkg::ADDR_TAKEY:
                    if (wdata_ff[7:0] == edxs_pkg::TA_KEY1)
                    begin
                        nxt_ta_stage = 2'h1;
                        nxt_ta_cnt = edxs_pkg::TA_WINDOW;
                    end
                    else if (ta_stage_ff == 2'h1 && wdata_ff[7:0] == edxs_pkg::TA_KEY2)
                    begin
                        nxt_ta_stage = 2'h2;
                        nxt_ta_cnt = edxs_pkg::TA_WINDOW;
                    end
                    else
                        nxt_ta_stage = 2'h0;
                edxs_pkg::ADDR_CMD:
                    if (cmd_go)
                        nxt_done = 1'b0;
                    else if (wdata_ff[8] == 1'b0 && wdata_ff[9])
                        nxt_done = 1'b0;
                edxs_pkg::ADDR_PTR0:
                    nxt_ptr0 = wdata_ff[15:0];
                edxs_pkg::ADDR_PTR1:
                    nxt_ptr1 = wdata_ff[15:0];
                edxs_pkg::ADDR_RIP2:
                begin
                    nxt_idx_reg = wdata_ff[7:0];
                    nxt_p2_latch = wdata_ff[15:8];
                end
                edxs_pkg::ADDR_STAT:
                    nxt_bresp = edxs_pkg::RESP_OKAY;
                default:
                    nxt_bresp = edxs_pkg::RESP_SLVERR;
            endcase
        end
        if (state_ff == edxs_pkg::EDXS_DONE && ptr_inc_ff)
        begin
            if (pointer_select_ff)
                nxt_ptr1 = ptr1_ff + 16'h0001;
            else
                nxt_ptr0 = ptr0_ff + 16'h0001;
        end
        if (state_ff == edxs_pkg::EDXS_DONE)
            nxt_done = 1'b1; // Completion wins over a same-cycle clear.
        if (s_axi_rvalid && s_axi_rready)
            nxt_rvalid = 1'b0;
        if (s_axi_arvalid && !rvalid_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp = edxs_pkg::RESP_OKAY;
            nxt_rdata = 32'h00000000;
            unique case (s_axi_araddr)
                edxs_pkg::ADDR_CLKCTL: nxt_rdata[2:0] = stretch_select_ff;
                edxs_pkg::ADDR_WAITCTL: nxt_rdata[edxs_pkg::WAIT_EN_BIT] = wait_enable_ff;
                edxs_pkg::ADDR_PSEL: nxt_rdata[0] = pointer_select_ff;
                edxs_pkg::ADDR_TAKEY: nxt_rdata[1:0] = ta_stage_ff;
                edxs_pkg::ADDR_CMD: nxt_rdata[9] = done_ff;
                edxs_pkg::ADDR_STAT: nxt_rdata = {22'h000000, run, done_ff, rd_data_ff};
                edxs_pkg::ADDR_PTR0: nxt_rdata[15:0] = ptr0_ff;
                edxs_pkg::ADDR_PTR1: nxt_rdata[15:0] = ptr1_ff;
                edxs_pkg::ADDR_RIP2: nxt_rdata[15:0] = {p2_latch_ff, idx_reg_ff};
                default: nxt_rresp = edxs_pkg::RESP_SLVERR;
            endcase
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            awaddr_ff <= 32'h00000000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            rvalid_ff <= 1'b0;
            rresp_ff <= 2'h0;
            rdata_ff <= 32'h00000000;
            stretch_select_ff <= edxs_pkg::STRETCH_RST;
            wait_enable_ff <= 1'b0;
            pointer_select_ff <= 1'b0;
            ptr0_ff <= 16'h0000;
            ptr1_ff <= 16'h0000;
            idx_reg_ff <= 8'h00;
            p2_latch_ff <= 8'h00;
            ta_stage_ff <= 2'h0;
            ta_cnt_ff <= 3'h0;
            done_ff <= 1'b0;
        end
        else
        begin
            aw_ok_ff <= nxt_aw_ok;
            w_ok_ff <= nxt_w_ok;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            stretch_select_ff <= nxt_stretch_select;
            wait_enable_ff <= nxt_wait_enable;
            pointer_select_ff <= nxt_pointer_select;
            ptr0_ff <= nxt_ptr0;
            ptr1_ff <= nxt_ptr1;
            idx_reg_ff <= nxt_idx_reg;
            p2_latch_ff <= nxt_p2_latch;
            ta_stage_ff <= nxt_ta_stage;
            ta_cnt_ff <= nxt_ta_cnt;
            done_ff <= nxt_done;
        end
    end
    // Access sequencer.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_mc_left = mc_left_ff;
        nxt_wait_pend = wait_pend_ff;
        nxt_is_write = is_write_ff;
        nxt_use_ptr = use_ptr_ff;
        nxt_ptr_inc = ptr_inc_ff;
        nxt_addr = addr_ff;
        nxt_wbyte = wbyte_ff;
        nxt_rd_n = rd_n_ff;
        nxt_wr_n = wr_n_ff;
        nxt_oe = oe_ff;
        nxt_rd_data = rd_data_ff;
        unique case (state_ff)
            edxs_pkg::EDXS_IDLE:
                if (cmd_go)
                begin
                    nxt_state = edxs_pkg::EDXS_FETCH;
                    nxt_is_write = wdata_ff[0];
                    nxt_use_ptr = wdata_ff[1];
                    nxt_ptr_inc = wdata_ff[2] && wdata_ff[1];
                    nxt_wbyte = wdata_ff[23:16];
                end
            edxs_pkg::EDXS_FETCH:
                if (last_clk)
                begin
                    nxt_state = edxs_pkg::EDXS_ACCESS;
                    nxt_mc_left = {1'b0, stretch_select_ff} + 4'h1;
                    nxt_wait_pend = 1'b0;
                    if (use_ptr_ff)
                        nxt_addr = pointer_select_ff ? ptr1_ff : ptr0_ff;
                    else
                        nxt_addr = {p2_latch_ff, idx_reg_ff};
                    nxt_oe = is_write_ff;
                end
            edxs_pkg::EDXS_ACCESS:
            begin
                // The strobe falls late enough to span two clocks, or four per stretch step.
                if ((phase == 2'h0 && stretch_select_ff == 3'h0)
                    || (phase == 2'h2 && stretch_select_ff != 3'h0
                    && mc_left_ff == {1'b0, stretch_select_ff} + 4'h1))
                begin
                    nxt_rd_n = is_write_ff;
                    nxt_wr_n = !is_write_ff;
                end
                if (phase == 2'h2)
                    nxt_wait_pend = wait_enable_ff && port4_bit0;
                if (last_clk)
                begin
                    if (wait_pend_ff)
                        nxt_mc_left = mc_left_ff;
                    else if (mc_left_ff != 4'h1)
                        nxt_mc_left = mc_left_ff - 4'h1;
                end
                // The strobe rises one clock before the cycle end so write data outlast it.
                if (phase == 2'h2 && mc_left_ff == 4'h1 && !(wait_enable_ff && port4_bit0))
                begin
                    nxt_rd_n = 1'b1;
                    nxt_wr_n = 1'b1;
                    if (!is_write_ff)
                        nxt_rd_data = ext_data_in;
                end
                if (last_clk && mc_left_ff == 4'h1 && !wait_pend_ff)
                begin
                    nxt_state = edxs_pkg::EDXS_DONE;
                    nxt_oe = 1'b0;
                end
            end
            edxs_pkg::EDXS_DONE:
                nxt_state = edxs_pkg::EDXS_IDLE;
        endcase
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= edxs_pkg::EDXS_IDLE;
            mc_left_ff <= 4'h0;
            wait_pend_ff <= 1'b0;
            is_write_ff <= 1'b0;
            use_ptr_ff <= 1'b0;
            ptr_inc_ff <= 1'b0;
            addr_ff <= 16'h0000;
            wbyte_ff <= 8'h00;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            oe_ff <= 1'b0;
            rd_data_ff <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            mc_left_ff <= nxt_mc_left;
            wait_pend_ff <= nxt_wait_pend;
            is_write_ff <= nxt_is_write;
            use_ptr_ff <= nxt_use_ptr;
            ptr_inc_ff <= nxt_ptr_inc;
            addr_ff <= nxt_addr;
            wbyte_ff <= nxt_wbyte;
            rd_n_ff <= nxt_rd_n;
            wr_n_ff <= nxt_wr_n;
            oe_ff <= nxt_oe;
            rd_data_ff <= nxt_rd_data;
        end
    end
    assign s_axi_awready = !aw_ok_ff;
    assign s_axi_wready = !w_ok_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign ext_addr = addr_ff;
    assign ext_data_out = wbyte_ff;
    assign ext_data_oe = oe_ff;
    assign ext_rd_n = rd_n_ff;
    assign ext_wr_n = wr_n_ff;
    assign core_hold = run;
    // Strobe width checks at stretch 0 and 1 with wait disabled.
    logic strobe_on;
    assign strobe_on = !rd_n_ff || !wr_n_ff;
    sequence s_strobe_fall;
        $fell(rd_n_ff && wr_n_ff);
    endsequence
    a_strobe_two_clk: assert property (@(posedge aclk) disable iff (!aresetn)
        s_strobe_fall and (stretch_select_ff == 3'h0) and !wait_enable_ff
        |-> strobe_on [*2] ##1 !strobe_on)
        else $error("Strobe width wrong at stretch zero.");
    a_strobe_four_clk: assert property (@(posedge aclk) disable iff (!aresetn)
        s_strobe_fall and (stretch_select_ff == 3'h1) and !wait_enable_ff
        |-> strobe_on [*4] ##1 !strobe_on)
        else $error("Strobe width wrong at stretch one.");
    a_fetch_four_clk: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(state_ff == edxs_pkg::EDXS_FETCH) |->
        (state_ff == edxs_pkg::EDXS_FETCH) [*4] ##1 (state_ff == edxs_pkg::EDXS_ACCESS))
        else $error("Opcode fetch not four clocks.");
    a_access_len: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(state_ff == edxs_pkg::EDXS_ACCESS) && stretch_select_ff == 3'h1 && !wait_enable_ff
        |-> (state_ff == edxs_pkg::EDXS_ACCESS) [*8] ##1 (state_ff == edxs_pkg::EDXS_DONE))
        else $error("Access length wrong for stretch one.");
    a_addr_ptr: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(state_ff == edxs_pkg::EDXS_ACCESS) && use_ptr_ff
        |-> ext_addr == (pointer_select_ff ? ptr1_ff : ptr0_ff))
        else $error("Pointer address mismatch.");
    a_addr_ind: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(state_ff == edxs_pkg::EDXS_ACCESS) && !use_ptr_ff
        |-> ext_addr == {p2_latch_ff, idx_reg_ff})
        else $error("Indirect address mismatch.");
    a_wait_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        !wait_enable_ff |-> !wait_pend_ff)
        else $error("Wait honoured while disabled.");
    a_wait_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        last_clk && wait_pend_ff && state_ff == edxs_pkg::EDXS_ACCESS
        |=> state_ff == edxs_pkg::EDXS_ACCESS && $stable(mc_left_ff))
        else $error("Wait cycle not inserted.");
    a_ws_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        !ta_open |=> $stable(wait_enable_ff))
        else $error("Wait enable changed without unlock.");
    a_hold_run: assert property (@(posedge aclk) disable iff (!aresetn)
        strobe_on |-> core_hold)
        else $error("Strobe outside held transfer.");
endmodule

// ---- dv/edxs_ext_mem.sv ----
// Behavioural external data memory with a programmable wait request.
`timescale 1ns/1ps
module edxs_ext_mem
(
    input wire logic aclk,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0] ext_data_out,
    input wire logic ext_rd_n,
    input wire logic ext_wr_n,
    input wire logic [3:0] wait_clks,
    output logic [7:0] ext_data_in,
    output logic port4_bit0
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_ff = 8'h00;
    int wcnt = 0;
    always @(posedge aclk)
    begin
        if (!ext_wr_n)
            mem[ext_addr] <= ext_data_out;
        if (!ext_rd_n)
            last_ff <= mem[ext_addr];
        wcnt <= (ext_rd_n && ext_wr_n) ? 0 : wcnt + 1;
    end
    // A released bus shows the inverse of the last byte, so stale data never looks right.
    assign ext_data_in = !ext_rd_n ? mem[ext_addr] : ~last_ff;
    // Wait is always released after a bounded number of clocks.
    assign port4_bit0 = (!ext_rd_n || !ext_wr_n) && (wcnt < int'(wait_clks));
endmodule

// ---- dv/test_edxs_top.sv ----
// Self-checking testbench for the external data access timing block.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module test_edxs_top;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = 4'hf, wait_clks = 4'h6;
    logic awready, wready, bvalid, arready, rvalid, p4, oe, rd_n, wr_n, core_hold;
    logic [1:0] bresp, rresp;
    logic [7:0] din, dout;
    logic [15:0] addr, stb_addr;
    int err_count = 0, samples_checked = 0, hold_cnt = 0, stb_cnt = 0;
    logic [7:0] exp_mem [int];
    edxs_top edxs_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port4_bit0(p4), .ext_data_in(din), .ext_addr(addr),
        .ext_data_out(dout), .ext_data_oe(oe), .ext_rd_n(rd_n), .ext_wr_n(wr_n),
        .core_hold(core_hold));
    edxs_ext_mem edxs_ext_mem_i (.aclk(aclk), .ext_addr(addr), .ext_data_out(dout),
        .ext_rd_n(rd_n), .ext_wr_n(wr_n), .wait_clks(wait_clks), .ext_data_in(din),
        .port4_bit0(p4));
    always #12.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        if (core_hold)
            hold_cnt++;
        if (!rd_n || !wr_n)
        begin
            stb_cnt++;
            stb_addr = addr;
        end
    end
    task automatic finish_test();
        $display("Errors %0d, comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ad, wd;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        ad = 0; wd = 0;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (awready && !ad) begin ad = 1; awvalid <= 1'b0; end
            if (wready && !wd) begin wd = 1; wvalid <= 1'b0; end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata; r = rresp;
        rready <= 1'b0;
    endtask
    // One transfer through the command register, timed at the strobes and the hold flag.
    task automatic xfer(input bit wr, input bit ptr, input logic [7:0] b, input int s,
        input bit w, input logic [15:0] a);
        logic [1:0] r;
        logic [31:0] st;
        int n;
        hold_cnt = 0; stb_cnt = 0; st = 32'h0; n = 0;
        axw(edxs_pkg::ADDR_CMD, {8'h00, b, 7'h00, 1'b1, 5'h00, ptr && !wr, ptr, wr}, r);
        while (st[8] !== 1'b1 && n < 100) begin axr(edxs_pkg::ADDR_STAT, st, r); n++; end
        `CHK(st[8], 1'b1)
        if (!w) `CHK(hold_cnt, (s + 2) * 4)
        if (!w) `CHK(stb_cnt, (s == 0) ? 2 : 4 * s)
        if (w) `CHK(stb_cnt > 2, 1'b1)
        `CHK(stb_addr, a)
        if (wr) exp_mem[a] = b;
        else `CHK(st[7:0], exp_mem[a])
        axw(edxs_pkg::ADDR_CMD, 32'h00000200, r);
    endtask
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] a;
        logic [7:0] b;
        void'($urandom(22044));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axr(edxs_pkg::ADDR_CLKCTL, d, r);
        `CHK(d[2:0], edxs_pkg::STRETCH_RST)
        axw(edxs_pkg::ADDR_PSEL, 32'h000000ff, r);
        axr(edxs_pkg::ADDR_PSEL, d, r);
        `CHK(d, 32'h00000001)
        axr(32'h00000040, d, r);
        `CHK(r, edxs_pkg::RESP_SLVERR)
        axw(edxs_pkg::ADDR_WAITCTL, 32'h00000080, r);
        axr(edxs_pkg::ADDR_WAITCTL, d, r);
        `CHK(d[7], 1'b0)
        for (int s = 0; s < 8; s++)
        begin
            axw(edxs_pkg::ADDR_CLKCTL, 32'(s), r);
            a = 16'($urandom); b = 8'($urandom);
            axw(s[0] ? edxs_pkg::ADDR_PTR1 : edxs_pkg::ADDR_PTR0, {16'h0, a}, r);
            axw(edxs_pkg::ADDR_PSEL, 32'(s[0]), r);
            xfer(1'b1, 1'b1, b, s, 1'b0, a);
            xfer(1'b0, 1'b1, 8'h00, s, 1'b0, a);
            axr(s[0] ? edxs_pkg::ADDR_PTR1 : edxs_pkg::ADDR_PTR0, d, r);
            `CHK(d[15:0], a + 16'h0001)
            a = 16'($urandom);
            axw(edxs_pkg::ADDR_RIP2, {16'h0, a}, r);
            xfer(1'b1, 1'b0, ~b, s, 1'b0, a);
            xfer(1'b0, 1'b0, 8'h00, s, 1'b0, a);
        end
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axr(edxs_pkg::ADDR_CLKCTL, d, r);
        `CHK(d[2:0], edxs_pkg::STRETCH_RST)
        axw(edxs_pkg::ADDR_RIP2, {16'h0, a}, r);
        axw(edxs_pkg::ADDR_TAKEY, {24'h0, edxs_pkg::TA_KEY1}, r);
        axw(edxs_pkg::ADDR_TAKEY, {24'h0, edxs_pkg::TA_KEY2}, r);
        axw(edxs_pkg::ADDR_WAITCTL, 32'h00000080, r);
        axr(edxs_pkg::ADDR_WAITCTL, d, r);
        `CHK(d[7], 1'b1)
        axw(edxs_pkg::ADDR_CLKCTL, 32'h00000000, r);
        xfer(1'b1, 1'b0, 8'h3c, 0, 1'b1, a);
        xfer(1'b0, 1'b0, 8'h00, 0, 1'b1, a);
        wait_clks <= 4'h0;
        xfer(1'b0, 1'b0, 8'h00, 0, 1'b0, a);
        finish_test();
    end
    initial
    begin
        #(25 * 60000);
        err_count++;
        finish_test();
    end
endmodule
